// ---- bench/sfl_checker.sv ----
// Concurrent checks on the wires of the flash link
`timescale 1ns/100ps
`default_nettype none
`include "sfl_map.svh"
module sfl_checker (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n
);
	// Slack for the host's request and launch stages
	localparam int SEL_CYC = `SFL_T_VCSL_CYC - 2;
	logic [11:0] age;
	logic [11:0] nb;
	logic [11:0] hb;
	logic [7:0] op;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			age <= '0;
			nb <= '0;
			op <= '0;
		end else begin
			if (age != 12'hFFF)
				age <= age + 12'h001;
			if (cs_n) begin
				nb <= '0;
			end else if ($rose(sck)) begin
				nb <= nb + 12'h001;
				if (nb < 12'h008)
					op <= {op[6:0], si};
			end
		end
	end
	// Header length in bits, worked out from the opcode
	always_comb begin
		case (op)
			8'h9F, 8'hB9, 8'hAB, 8'hD7: hb = 12'h008;
			8'hD2, 8'hE8: hb = 12'h040;
			8'hD4, 8'hD6, 8'h0B: hb = 12'h028;
			default: hb = 12'h020;
		endcase
	end
	////////////////////////////////////////////////////////////
	oe_reset_a: assert property ($rose(nrst_i) |-> so_oe_n)
		else $error("output enabled at reset release");
	cs_oe_a: assert property (cs_n |-> so_oe_n)
		else $error("output enabled while deselected");
	so_idle_a: assert property (so_oe_n |-> !so)
		else $error("data line not parked low");
	sel_wait_a: assert property (age < SEL_CYC |-> cs_n)
		else $error("select too soon after power-up");
	lead_a: assert property ($fell(cs_n) |-> sck [*4])
		else $error("clock not idle at select");
	rise_sel_a: assert property ($rose(sck) |-> !cs_n)
		else $error("clock edge outside a frame");
	si_hold_a: assert property (
		!cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(si))
		else $error("data in moved while clock high");
	hdr_len_a: assert property ($fell(so_oe_n) |-> nb == hb)
		else $error("output started at wrong bit");
	cover property ($fell(cs_n));
	cover property ($fell(so_oe_n));
	cover property ($rose(cs_n) ##1 cs_n);
endmodule : sfl_checker
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench: host and flash ends joined on one link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic por_ok_i = 1'b1;
	logic req_i = 1'b0;
	logic [7:0] opcode_i = 8'h00;
	logic [10:0] page_i = 11'h000;
	logic [8:0] byte_i = 9'h000;
	logic [7:0] rd_len_i = 8'h00;
	logic ready_o, write_ok_o, rd_valid_o, done_o, sb, m3, cv, sb2, m32, cv2;
	logic [7:0] rd_data_o, cop, cop2;
	logic [10:0] cpg;
	logic [8:0] cby;
	logic got, got2;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] rng = 32'hC351C361;
	logic [7:0] rq[$];
	logic [7:0] ops[9] = '{8'h03, 8'h0B, 8'hD2, 8'hE8, 8'hD4, 8'hD6,
		8'h87, 8'h82, 8'h9F};
	sfl_if lk();
	sfl_if lk2();
	////////////////////////////////////////////////////////////
	sfl_host #(.HALF_CYC(4), .WR_DLY_CYC(2000), .SCK_IDLE_HIGH(1'b1))
	i_sfl_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(lk.host),
		.req_i(req_i), .opcode_i(opcode_i), .page_i(page_i),
		.byte_i(byte_i), .rd_len_i(rd_len_i), .ready_o(ready_o),
		.write_ok_o(write_ok_o), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .done_o(done_o));
	sfl_dev i_sfl_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.por_ok_i(por_ok_i), .link(lk.dev), .standby_o(sb), .mode3_o(m3),
		.cmd_valid_o(cv), .cmd_opcode_o(cop), .cmd_page_o(cpg),
		.cmd_byte_o(cby));
	// Second flash end, driven by the bench in clock mode 0
	sfl_dev i_sfl_dev2 (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.por_ok_i(por_ok_i), .link(lk2.dev), .standby_o(sb2),
		.mode3_o(m32), .cmd_valid_o(cv2), .cmd_opcode_o(cop2),
		.cmd_page_o(), .cmd_byte_o());
	sfl_checker i_sfl_checker (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si), .so(lk.so),
		.so_oe_n(lk.so_oe_n));
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (rd_valid_o === 1'b1)
			rq.push_back(rd_data_o);
		if (cv === 1'b1)
			got = 1'b1;
		if (cv2 === 1'b1)
			got2 = 1'b1;
	end
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		nxt = x ^ (x << 5);
	endfunction : nxt
	function automatic logic [7:0] exp_rd(input logic [8:0] b, input int k);
		exp_rd = b[7:0] + 8'(k);
	endfunction : exp_rd
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim();
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic xfer(input logic [7:0] op, input logic [7:0] n,
		input logic pa, input logic ba, input logic live);
		int k;
		rng = nxt(rng);
		@(negedge clk_sys_i);
		opcode_i = op;
		page_i = rng[10:0];
		byte_i = rng[20:12];
		rd_len_i = n;
		got = 1'b0;
		rq.delete();
		for (k = 0; ready_o !== 1'b1 && k < 9000; k++)
			@(negedge clk_sys_i);
		chk(32'(k >= 9000), 32'h0);
		req_i = 1'b1;
		@(negedge clk_sys_i);
		req_i = 1'b0;
		for (k = 0; done_o !== 1'b1 && k < 9000; k++)
			@(negedge clk_sys_i);
		chk(32'(k >= 9000), 32'h0);
		chk(got, live);
		if (live) begin
			chk(cop, op);
			if (pa)
				chk(cpg, page_i);
			if (ba)
				chk(cby, byte_i);
		end
		chk(rq.size(), n);
		foreach (rq[i])
			chk(rq[i], live ? exp_rd(byte_i, i) : 8'h00);
	endtask : xfer
	// Bench-made link clock at 125 ns; cs high means no select at all
	task automatic frm2(input logic [31:0] w, input logic cs);
		lk2.sck = 1'b0;
		got2 = 1'b0;
		#250 lk2.cs_n = cs;
		#250;
		for (int b = 31; b >= 0; b--) begin
			lk2.si = w[b];
			#62.5 lk2.sck = 1'b1;
			#62.5 lk2.sck = 1'b0;
		end
		#250 lk2.cs_n = 1'b1;
		#500;
	endtask : frm2
	////////////////////////////////////////////////////////////
	initial begin
		#4000000;
		n_errors++;
		end_sim();
	end
	initial begin
		lk2.cs_n = 1'b0;
		lk2.sck = 1'b0;
		lk2.si = 1'b0;
		repeat (20) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		chk(sb, 1'b1);
		chk(m3, 1'b1);
		chk(lk.so_oe_n, 1'b1);
		chk(sb2, 1'b0);
		chk(ready_o, 1'b0);
		repeat (1760) @(negedge clk_sys_i);
		chk(ready_o, 1'b1);
		opcode_i = 8'h82;
		#1 chk(ready_o, 1'b0);
		chk(write_ok_o, 1'b0);
		frm2(32'h0300AA55, 1'b1);
		chk(got2, 1'b0);
		frm2(32'h0300AA55, 1'b0);
		chk(got2, 1'b1);
		chk(cop2, 8'h03);
		chk(m32, 1'b0);
		for (int r = 0; r < 2; r++)
			for (int i = 0; i < 9; i++)
				xfer(ops[i], (i < 6) ? 8'(rng[1:0] + 2'h1) : 8'h00,
					i < 4 || i == 7, i < 8, 1'b1);
		chk(write_ok_o, 1'b1);
		por_ok_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		chk(sb, 1'b0);
		chk(m32, 1'b1);
		xfer(8'h03, 8'h02, 1'b1, 1'b1, 1'b0);
		por_ok_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		chk(sb, 1'b1);
		xfer(8'hD2, 8'h03, 1'b1, 1'b1, 1'b1);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire

// ---- hdl/sfl_dev.sv ----
// Flash-side end of the serial command link: frame decode and power state
`timescale 1ns/100ps
`default_nettype none
module sfl_dev
	import sfl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic por_ok_i,
	sfl_if.dev link,
	output logic standby_o,
	output logic mode3_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_opcode_o,
	output logic [10:0] cmd_page_o,
	output logic [8:0] cmd_byte_o
);

	////////////////////////////////////////////////////////////////////////
	// Link clock domain: shift in opcode, address and don't-care bytes

	sfl_frm_s frm;
	sfl_frm_s next_frm;
	sfl_hold_s hold;
	sfl_hold_s next_hold;
	sfl_out_s outp;
	sfl_out_s next_outp;
	logic frm_rst;
	logic hold_rst;
	logic [7:0] byte_in;
	logic [7:0] op_now;
	logic [7:0] cur;

	// The link clock only runs inside frames, so the frame is ended by
	// chip select itself rather than by anything clocked
	assign frm_rst = link.cs_n | ~por_ok_i;
	assign hold_rst = ~por_ok_i;

	always_comb begin
		next_frm = frm;
		byte_in = {frm.sh[6:0], link.si};
		op_now = (frm.bits == 7'h07) ? byte_in : frm.op;
		if (!frm.hdr) begin
			next_frm.sh = byte_in;
			next_frm.bits = frm.bits + 7'h01;
			if (frm.bits == 7'h07) begin
				next_frm.op = byte_in;
			end else if (frm.bits[2:0] == 3'h7 &&
				frm.bits < sfl_addr_end(frm.op)) begin
				next_frm.addr = {frm.addr[15:0], byte_in};
			end
			// Don't-care bytes are counted but not kept
			if (7'(frm.bits + 7'h01) == sfl_hdr_bits(op_now)) begin
				next_frm.hdr = 1'b1;
			end
		end
	end

	always_ff @(posedge link.sck or posedge frm_rst) begin
		if (frm_rst) begin
			frm <= '0;
		end else begin
			frm <= next_frm;
		end
	end

	// Command words held across frames for the system side to pick up
	always_comb begin
		next_hold = hold;
		if (next_frm.hdr && !frm.hdr) begin
			next_hold.tgl = ~hold.tgl;
			next_hold.op = op_now;
			next_hold.addr = next_frm.addr;
		end
	end

	always_ff @(posedge link.sck or posedge hold_rst) begin
		if (hold_rst) begin
			hold <= '0;
		end else begin
			hold <= next_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link clock domain: read data launched on the falling clock edge

	// Returned bytes count up from the addressed byte; the memory array
	// itself lies outside this block
	always_comb begin
		next_outp = outp;
		cur = outp.act ? outp.obyte : frm.addr[7:0];
		if (frm.hdr) begin
			next_outp.act = 1'b1;
			next_outp.oe_n = 1'b0;
			next_outp.so = cur[3'h7 - outp.obit];
			next_outp.obit = outp.obit + 3'h1;
			if (outp.obit == 3'h7) begin
				next_outp.obyte = cur + 8'h01;
			end else begin
				next_outp.obyte = cur;
			end
		end
	end

	always_ff @(negedge link.sck or posedge frm_rst) begin
		if (frm_rst) begin
			outp <= `SFL_OUT_RST;
		end else begin
			outp <= next_outp;
		end
	end

	assign link.so = outp.so;
	assign link.so_oe_n = outp.oe_n;

	////////////////////////////////////////////////////////////////////////
	// System clock domain: power state, clock mode and command hand-over

	sfl_dsys_s sys;
	sfl_dsys_s next_sys;
	logic new_cmd;

	assign new_cmd = sys.tgl_s[2] ^ sys.tgl_s[1];

	always_comb begin
		next_sys = sys;
		next_sys.vld = 1'b0;
		next_sys.cs_s = {sys.cs_s[0], link.cs_n};
		next_sys.sck_s = {sys.sck_s[0], link.sck};
		next_sys.por_s = {sys.por_s[0], por_ok_i};
		next_sys.tgl_s = {sys.tgl_s[1:0], hold.tgl};
		case (sys.st)
			SFL_D_RESET: begin
				// A frame already under way at release is not joined
				if (sys.por_s[1] && sys.cs_s[1]) begin
					next_sys.st = SFL_D_STANDBY;
				end
			end
			SFL_D_STANDBY: begin
				if (!sys.cs_s[1]) begin
					next_sys.st = SFL_D_SELECT;
					next_sys.mode3 = sys.sck_s[1];
				end
			end
			SFL_D_SELECT: begin
				// Held words changed a full sync delay ago, so stable
				if (new_cmd) begin
					next_sys.vld = 1'b1;
					next_sys.op = hold.op;
					next_sys.addr = hold.addr;
				end
				if (sys.cs_s[1]) begin
					next_sys.st = SFL_D_STANDBY;
				end
			end
			default: begin
				next_sys.st = SFL_D_RESET;
			end
		endcase
		if (!sys.por_s[1]) begin
			next_sys.st = SFL_D_RESET;
			next_sys.vld = 1'b0;
			next_sys.mode3 = `SFL_MODE3_DEFAULT;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys <= '0;
			sys.st <= SFL_D_RESET;
			sys.cs_s <= 2'h3;
			sys.mode3 <= `SFL_MODE3_DEFAULT;
		end else begin
			sys <= next_sys;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// User-side outputs

	assign standby_o = (sys.st == SFL_D_STANDBY);
	assign mode3_o = sys.mode3;
	assign cmd_valid_o = sys.vld;
	assign cmd_opcode_o = sys.op;
	assign cmd_page_o = sys.addr[`SFL_PAGE_MSB:`SFL_PAGE_LSB];
	assign cmd_byte_o = sys.addr[`SFL_BYTE_MSB:0];

endmodule : sfl_dev
`default_nettype wire

// ---- hdl/sfl_host.sv ----
// Host-side end of the serial flash link: power-up waits and framing
`timescale 1ns/100ps
`default_nettype none
module sfl_host
	import sfl_pkg::*;
#(
	parameter int HALF_CYC = 4,
	parameter int WR_DLY_CYC = `SFL_T_PUW_CYC,
	parameter bit SCK_IDLE_HIGH = `SFL_MODE3_DEFAULT
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	sfl_if.host link,
	input wire logic req_i,
	input wire logic [7:0] opcode_i,
	input wire logic [10:0] page_i,
	input wire logic [8:0] byte_i,
	input wire logic [7:0] rd_len_i,
	output logic ready_o,
	output logic write_ok_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic done_o
);

	// Read data passes a two-stage sync, so each half clock needs room
	if (HALF_CYC < 3 || HALF_CYC > 15) begin : g_bad_half
		$error("HALF_CYC must lie in 3..15");
	end
	if (WR_DLY_CYC < `SFL_T_VCSL_CYC || WR_DLY_CYC >= 524288) begin : g_bad_wr
		$error("WR_DLY_CYC out of range");
	end

	localparam logic [3:0] HALF_M1 = 4'(HALF_CYC - 1);
	localparam logic [18:0] SEL_CYC = 19'(`SFL_T_VCSL_CYC);
	localparam logic [18:0] WR_CYC = 19'(WR_DLY_CYC);

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer

	sfl_host_s h;
	sfl_host_s next_h;
	logic wr_ok;
	logic [7:0] rx_new;

	assign wr_ok = (h.pwr == WR_CYC);
	assign ready_o = (h.st == SFL_H_IDLE) &&
		(!sfl_is_prog(opcode_i) || wr_ok);

	always_comb begin
		next_h = h;
		next_h.rvld = 1'b0;
		next_h.done = 1'b0;
		next_h.so_s = {h.so_s[0], link.so};
		rx_new = {h.rx[6:0], h.so_s[1]};
		if (!wr_ok) begin
			next_h.pwr = h.pwr + 19'h00001;
		end
		case (h.st)
			SFL_H_WAIT: begin
				if (h.pwr >= SEL_CYC) begin
					next_h.st = SFL_H_IDLE;
				end
			end
			SFL_H_IDLE: begin
				if (req_i && ready_o) begin
					next_h.cs_n = 1'b0;
					next_h.si = opcode_i[7];
					next_h.tx = {opcode_i[6:0], 4'h0, page_i, byte_i, 1'b0};
					next_h.hdr = sfl_hdr_bits(opcode_i);
					next_h.tot = 12'(sfl_hdr_bits(opcode_i)) +
						{1'b0, rd_len_i, 3'b000};
					next_h.bits = '0;
					next_h.div = '0;
					next_h.st = SFL_H_LEAD;
				end
			end
			SFL_H_LEAD: begin
				// Clock holds its idle level while the flash samples it
				next_h.div = h.div + 4'h1;
				if (h.div == HALF_M1) begin
					next_h.div = '0;
					next_h.sck = 1'b0;
					next_h.st = SFL_H_SHIFT;
				end
			end
			SFL_H_SHIFT: begin
				next_h.div = h.div + 4'h1;
				if (h.div == HALF_M1) begin
					next_h.div = '0;
					if (!h.sck) begin
						next_h.sck = 1'b1;
					end else begin
						if (h.bits >= 12'(h.hdr)) begin
							next_h.rx = rx_new;
							if (h.bits[2:0] == 3'h7) begin
								next_h.rdat = rx_new;
								next_h.rvld = 1'b1;
							end
						end
						next_h.bits = h.bits + 12'h001;
						if (h.bits == h.tot - 12'h001) begin
							next_h.sck = SCK_IDLE_HIGH;
							next_h.st = SFL_H_TAIL;
						end else begin
							next_h.sck = 1'b0;
							next_h.si = h.tx[31];
							next_h.tx = {h.tx[30:0], 1'b0};
						end
					end
				end
			end
			SFL_H_TAIL: begin
				next_h.div = h.div + 4'h1;
				if (h.div == HALF_M1) begin
					next_h.div = '0;
					if (!h.cs_n) begin
						next_h.cs_n = 1'b1;
						next_h.si = 1'b0;
					end else begin
						next_h.st = SFL_H_IDLE;
						next_h.done = 1'b1;
					end
				end
			end
			default: begin
				next_h.st = SFL_H_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			h <= '0;
			h.st <= SFL_H_WAIT;
			h.cs_n <= 1'b1;
			h.sck <= SCK_IDLE_HIGH;
		end else begin
			h <= next_h;
		end
	end

	assign link.cs_n = h.cs_n;
	assign link.sck = h.sck;
	assign link.si = h.si;
	assign write_ok_o = wr_ok;
	assign rd_valid_o = h.rvld;
	assign rd_data_o = h.rdat;
	assign done_o = h.done;

endmodule : sfl_host
`default_nettype wire

// ---- hdl/sfl_if.sv ----
// Serial flash command link between host controller and flash device
`timescale 1ns/100ps
`default_nettype none
interface sfl_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe_n;

	modport dev (
		input cs_n,
		input sck,
		input si,
		output so,
		output so_oe_n
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		input so,
		input so_oe_n
	);
endinterface : sfl_if
`default_nettype wire

// ---- hdl/sfl_map.svh ----
// Constants of the serial flash command link: opcodes, layout, timing
`ifndef SFL_MAP_SVH
`define SFL_MAP_SVH

// Idle clock level chosen after any reset: high means clock mode 3
`define SFL_MODE3_DEFAULT 1'b1

// Address layout: 4 don't-care bits, 11 page bits, 9 byte bits
`define SFL_ADDR_BYTES 3'h3
`define SFL_PAGE_MSB 19
`define SFL_PAGE_LSB 9
`define SFL_BYTE_MSB 8
`define SFL_DUMMY_LONG 3'h4
`define SFL_DUMMY_SHORT 3'h1

// Opcode groups, written as case item lists
`define SFL_OPS_NOADDR 8'h9F, 8'hB9, 8'hAB, 8'hD7
`define SFL_OPS_DUMMY4 8'hD2, 8'hE8
`define SFL_OPS_DUMMY1 8'hD4, 8'hD6, 8'h0B
`define SFL_OPS_PROG 8'h50, 8'h58, 8'h59, 8'h7C, 8'h81, 8'h82, 8'h83, \
	8'h85, 8'h86, 8'h88, 8'h89

// Power-up waits, in their own units and in system clock cycles
`define SFL_CLK_MHZ 25
`define SFL_T_VCSL_US 70
`define SFL_T_VCSL_CYC (`SFL_T_VCSL_US * `SFL_CLK_MHZ)
`define SFL_T_PUW_MS 20
`define SFL_T_PUW_CYC (`SFL_T_PUW_MS * 1000 * `SFL_CLK_MHZ)

// Link output stage reset value: idle, output enable off (low-active)
`define SFL_OUT_RST 14'h0001

`endif

// ---- hdl/sfl_pkg.sv ----
// Types and opcode decoders shared by both ends of the flash link
`include "sfl_map.svh"
package sfl_pkg;

	typedef enum logic [2:0] {
		SFL_D_RESET = 3'b001,
		SFL_D_STANDBY = 3'b010,
		SFL_D_SELECT = 3'b100
	} sfl_dev_st_e;

	typedef enum logic [4:0] {
		SFL_H_WAIT = 5'b00001,
		SFL_H_IDLE = 5'b00010,
		SFL_H_LEAD = 5'b00100,
		SFL_H_SHIFT = 5'b01000,
		SFL_H_TAIL = 5'b10000
	} sfl_host_st_e;

	typedef struct packed {
		logic [6:0] bits;
		logic [7:0] sh;
		logic [7:0] op;
		logic [23:0] addr;
		logic hdr;
	} sfl_frm_s;

	typedef struct packed {
		logic tgl;
		logic [7:0] op;
		logic [23:0] addr;
	} sfl_hold_s;

	typedef struct packed {
		logic act;
		logic [2:0] obit;
		logic [7:0] obyte;
		logic so;
		logic oe_n;
	} sfl_out_s;

	typedef struct packed {
		sfl_dev_st_e st;
		logic [1:0] cs_s;
		logic [1:0] sck_s;
		logic [1:0] por_s;
		logic [2:0] tgl_s;
		logic mode3;
		logic vld;
		logic [7:0] op;
		logic [23:0] addr;
	} sfl_dsys_s;

	typedef struct packed {
		sfl_host_st_e st;
		logic [18:0] pwr;
		logic [3:0] div;
		logic [11:0] bits;
		logic [11:0] tot;
		logic [6:0] hdr;
		logic [31:0] tx;
		logic [7:0] rx;
		logic [1:0] so_s;
		logic cs_n;
		logic sck;
		logic si;
		logic rvld;
		logic done;
		logic [7:0] rdat;
	} sfl_host_s;

	function automatic logic [2:0] sfl_addr_bytes(input logic [7:0] op);
		case (op)
			`SFL_OPS_NOADDR: sfl_addr_bytes = 3'h0;
			default: sfl_addr_bytes = `SFL_ADDR_BYTES;
		endcase
	endfunction : sfl_addr_bytes

	function automatic logic [2:0] sfl_dummy_bytes(input logic [7:0] op);
		case (op)
			`SFL_OPS_DUMMY4: sfl_dummy_bytes = `SFL_DUMMY_LONG;
			`SFL_OPS_DUMMY1: sfl_dummy_bytes = `SFL_DUMMY_SHORT;
			default: sfl_dummy_bytes = 3'h0;
		endcase
	endfunction : sfl_dummy_bytes

	// Bits before read data: opcode, address and don't-care bytes
	function automatic logic [6:0] sfl_hdr_bits(input logic [7:0] op);
		logic [3:0] n;
		n = 4'(sfl_addr_bytes(op)) + 4'(sfl_dummy_bytes(op)) + 4'h1;
		sfl_hdr_bits = {n, 3'b000};
	endfunction : sfl_hdr_bits

	function automatic logic [6:0] sfl_addr_end(input logic [7:0] op);
		logic [3:0] n;
		n = 4'(sfl_addr_bytes(op)) + 4'h1;
		sfl_addr_end = {n, 3'b000};
	endfunction : sfl_addr_end

	function automatic logic sfl_is_prog(input logic [7:0] op);
		case (op)
			`SFL_OPS_PROG: sfl_is_prog = 1'b1;
			default: sfl_is_prog = 1'b0;
		endcase
	endfunction : sfl_is_prog

endpackage : sfl_pkg
